//--- rtl/emb_mult.sv
// Embedded multiplier block: one 18x18 or two 9x9 multipliers with optional registers
module emb_mult (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire emb_pkg::emb_mode_t mode_i,
    input wire logic [emb_pkg::WIDE_W-1:0] data_a_i,
    input wire logic [emb_pkg::WIDE_W-1:0] data_b_i,
    input wire logic sign_a_i = emb_pkg::SIGN_RST,
    input wire logic sign_b_i = emb_pkg::SIGN_RST,
    input wire logic [emb_pkg::SELS-1:0] in_reg_en_i,
    input wire logic sign_a_reg_en_i,
    input wire logic sign_b_reg_en_i,
    input wire logic [emb_pkg::LANES-1:0] out_reg_en_i,
    output logic [emb_pkg::WIDE_P_W-1:0] result_o,
    output logic result_signed_o
);
    localparam int NW = emb_pkg::NARROW_W;
    localparam int NP = emb_pkg::NARROW_P_W;
    localparam int WW = emb_pkg::WIDE_W;
    localparam int WP = emb_pkg::WIDE_P_W;

    // ***********************
    // Product and select helpers
    // ***********************
    // Operands sign-extended to product width, so the low bits are exact for any sign mix
    function automatic logic [WP-1:0] mul_wide(
        input logic [WW-1:0] a,
        input logic [WW-1:0] b,
        input logic sa,
        input logic sb
    );
        logic [WP-1:0] ea;
        logic [WP-1:0] eb;
        ea = {{WW{sa & a[WW-1]}}, a};
        eb = {{WW{sb & b[WW-1]}}, b};
        return ea * eb;
    endfunction

    function automatic logic [NP-1:0] mul_narrow(
        input logic [NW-1:0] a,
        input logic [NW-1:0] b,
        input logic sa,
        input logic sb
    );
        logic [NP-1:0] ea;
        logic [NP-1:0] eb;
        ea = {{NW{sa & a[NW-1]}}, a};
        eb = {{NW{sb & b[NW-1]}}, b};
        return ea * eb;
    endfunction

    // Bypass flag of one stage; in wide mode an upper select copies the lower one
    function automatic logic sel_byp(
        input logic wide_m,
        input logic en_own,
        input logic en_lo
    );
        return wide_m ? ~en_lo : ~en_own;
    endfunction

    // ***********************
    // Input registers
    // ***********************
    // Four 9-bit input sections: low and high halves of A and B
    logic [WW-1:0] opnd_a;
    logic [WW-1:0] opnd_b;
    logic sgn_a;
    logic sgn_b;
    logic [emb_pkg::SELS-1:0] in_byp;
    logic [NW-1:0] in_d [emb_pkg::SELS];
    logic [NW-1:0] in_q [emb_pkg::SELS];
    logic wide;

    assign wide = (mode_i == emb_pkg::EMB_MODE_WIDE);
    assign in_d[emb_pkg::SEL_A0] = data_a_i[NW-1:0];
    assign in_d[emb_pkg::SEL_B0] = data_b_i[NW-1:0];
    assign in_d[emb_pkg::SEL_A1] = data_a_i[WW-1:NW];
    assign in_d[emb_pkg::SEL_B1] = data_b_i[WW-1:NW];

    // Wide mode: upper half follows the lower half's choice per operand
    always_comb begin
        in_byp[emb_pkg::SEL_A0] = ~in_reg_en_i[emb_pkg::SEL_A0];
        in_byp[emb_pkg::SEL_B0] = ~in_reg_en_i[emb_pkg::SEL_B0];
        in_byp[emb_pkg::SEL_A1] = sel_byp(wide, in_reg_en_i[emb_pkg::SEL_A1], in_reg_en_i[emb_pkg::SEL_A0]);
        in_byp[emb_pkg::SEL_B1] = sel_byp(wide, in_reg_en_i[emb_pkg::SEL_B1], in_reg_en_i[emb_pkg::SEL_B0]);
    end

    // Input sections share the block's clock, enable and clear
    genvar gi;
    generate
        for (gi = 0; gi < emb_pkg::SELS; gi++) begin : g_in
            emb_opt_reg #(.W(NW)) u_in (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .bypass_i(in_byp[gi]),
                .d_i(in_d[gi]),
                .q_o(in_q[gi])
            );
        end
    endgenerate

    // Registered or bypassed halves rejoin into full operands
    assign opnd_a = {in_q[emb_pkg::SEL_A1], in_q[emb_pkg::SEL_A0]};
    assign opnd_b = {in_q[emb_pkg::SEL_B1], in_q[emb_pkg::SEL_B0]};

    // ***********************
    // Sign controls
    // ***********************
    // One sign register per operand serves both narrow lanes
    logic sgn_a_byp;
    logic sgn_b_byp;

    assign sgn_a_byp = ~sign_a_reg_en_i;
    assign sgn_b_byp = ~sign_b_reg_en_i;

    emb_opt_reg #(.W(1)) u_sgn_a (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .bypass_i(sgn_a_byp),
        .d_i(sign_a_i),
        .q_o(sgn_a)
    );

    emb_opt_reg #(.W(1)) u_sgn_b (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .bypass_i(sgn_b_byp),
        .d_i(sign_b_i),
        .q_o(sgn_b)
    );

    // ***********************
    // Multiplier stage
    // ***********************
    logic [WP-1:0] prod;
    logic [NW-1:0] lane_a [emb_pkg::LANES];
    logic [NW-1:0] lane_b [emb_pkg::LANES];
    logic [NP-1:0] prod_lane [emb_pkg::LANES];
    logic prod_signed;

    // Two independent narrow lanes on the halves of both operands
    generate
        for (gi = 0; gi < emb_pkg::LANES; gi++) begin : g_lane
            assign lane_a[gi] = opnd_a[gi*NW +: NW];
            assign lane_b[gi] = opnd_b[gi*NW +: NW];
            assign prod_lane[gi] = mul_narrow(lane_a[gi], lane_b[gi], sgn_a, sgn_b);
        end
    endgenerate

    // Mode is a static level; a change mid-stream mixes stale register halves
    always_comb begin
        if (wide) begin
            prod = mul_wide(opnd_a, opnd_b, sgn_a, sgn_b);
        end else begin
            prod = {prod_lane[emb_pkg::HALF_HI], prod_lane[emb_pkg::HALF_LO]};
        end
        prod_signed = sgn_a | sgn_b;
    end

    // ***********************
    // Output registers
    // ***********************
    // One 36-bit section in wide mode, two 18-bit sections in dual mode
    logic [emb_pkg::LANES-1:0] out_byp;
    logic [WP-1:0] res;
    logic res_sgn;

    always_comb begin
        out_byp[emb_pkg::HALF_LO] = ~out_reg_en_i[emb_pkg::HALF_LO];
        out_byp[emb_pkg::HALF_HI] = sel_byp(wide, out_reg_en_i[emb_pkg::HALF_HI],
                                            out_reg_en_i[emb_pkg::HALF_LO]);
    end

    generate
        for (gi = 0; gi < emb_pkg::LANES; gi++) begin : g_out
            emb_opt_reg #(.W(NP)) u_out (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .bypass_i(out_byp[gi]),
                .d_i(prod[gi*NP +: NP]),
                .q_o(res[gi*NP +: NP])
            );
        end
    endgenerate

    // Result sign follows the lower section's register choice
    emb_opt_reg #(.W(1)) u_out_sgn (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .bypass_i(out_byp[emb_pkg::HALF_LO]),
        .d_i(prod_signed),
        .q_o(res_sgn)
    );

    // ***********************
    // Result drive
    // ***********************
    assign result_o = res;
    assign result_signed_o = res_sgn;
endmodule // emb_mult

//--- rtl/emb_pkg.sv
// Package of widths, modes and reset values for the embedded multiplier block
package emb_pkg;
    // ***********************
    // Widths
    // ***********************
    localparam int WIDE_W = 18;
    localparam int NARROW_W = 9;
    localparam int WIDE_P_W = 36;
    localparam int NARROW_P_W = 18;
    localparam int HALF_LO = 0;
    localparam int HALF_HI = 1;
    localparam int LANES = 2;
    localparam int SELS = 4;
    // ***********************
    // Register select bits
    // ***********************
    localparam int SEL_A0 = 0;
    localparam int SEL_B0 = 1;
    localparam int SEL_A1 = 2;
    localparam int SEL_B1 = 3;
    localparam logic [WIDE_W-1:0] OPND_RST = 18'h00000;
    localparam logic [WIDE_P_W-1:0] PROD_RST = 36'h000000000;
    localparam logic SIGN_RST = 1'b0;
    // ***********************
    // Modes
    // ***********************
    typedef enum logic {
        EMB_MODE_WIDE,
        EMB_MODE_DUAL
    } emb_mode_t;
endpackage

//--- rtl/emb_opt_reg.sv
// Optional register stage with shared enable and asynchronous clear
module emb_opt_reg #(
    parameter int W = 18
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic bypass_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] held;
    logic [W-1:0] next_held;

    always_comb begin
        next_held = ce_i ? d_i : held;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            held <= '0;
        end else begin
            held <= next_held;
        end
    end

    assign q_o = bypass_i ? d_i : held;
endmodule // emb_opt_reg

//--- testbench/emb_mult_monitor.sv
// Port checker of the embedded multiplier
module emb_mult_monitor (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire emb_pkg::emb_mode_t mode_i,
    input wire logic [17:0] data_a_i,
    input wire logic [17:0] data_b_i,
    input wire logic sign_a_i,
    input wire logic sign_b_i,
    input wire logic [3:0] in_reg_en_i,
    input wire logic sign_a_reg_en_i,
    input wire logic sign_b_reg_en_i,
    input wire logic [1:0] out_reg_en_i,
    input wire logic [35:0] result_o,
    input wire logic result_signed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] k;
    logic [35:0] p;
    logic s;
    assign k = {mode_i, in_reg_en_i, out_reg_en_i, sign_a_reg_en_i, sign_b_reg_en_i};
    assign p = 36'($signed({sign_a_i & data_a_i[17], data_a_i}) * $signed({sign_b_i & data_b_i[17], data_b_i}));
    assign s = sign_a_i | sign_b_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_comb_prod: assert property (k == 9'h000 |-> result_o == p)
        else $error("wide product wrong");
    a_sign_flag: assert property (k == 9'h000 |-> result_signed_o == s)
        else $error("signed flag wrong");
    a_out_reg: assert property (ce_i && k == 9'h00c ##1 k == 9'h00c |-> result_o == $past(p))
        else $error("output stage wrong");
    a_in_reg: assert property (ce_i && k == 9'h0f3 ##1 k == 9'h0f3 |-> result_o == $past(p))
        else $error("input stage wrong");
    a_two_stage: assert property ((ce_i && k == 9'h0ff)[*2] ##1 k == 9'h0ff |-> result_o == $past(p, 2))
        else $error("two stage latency wrong");
    a_flag_delay: assert property ((ce_i && k[7:0] == 8'hff)[*2] ##1 k[7:0] == 8'hff |-> result_signed_o == $past(s, 2))
        else $error("registered flag wrong");
    a_ce_hold: assert property (!ce_i && k[7:0] == 8'hff ##1 k[7:0] == 8'hff |-> $stable(result_o))
        else $error("result moved while disabled");
    a_clear_zero: assert property (disable iff (1'b0) sys_rst_i && k[7:0] == 8'hff |-> result_o == 36'h0 && !result_signed_o)
        else $error("clear left data");
    c_freeze: cover property (!ce_i && k[7:0] == 8'hff);
    c_dual: cover property (mode_i == emb_pkg::EMB_MODE_DUAL && k[7:0] == 8'h00);
    c_signed: cover property (k == 9'h0ff && sign_a_i && sign_b_i);
endmodule // emb_mult_monitor
bind emb_mult emb_mult_monitor u_mon (.*);

//--- testbench/emb_fabric_model.sv
// Fabric model that launches operands and sign controls
module emb_fabric_model (
    input wire logic clk_sys_i,
    input wire logic [37:0] nxt_i,
    output logic [17:0] data_a_o,
    output logic [17:0] data_b_o,
    output logic sign_a_o,
    output logic sign_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Launched off the sampling edge; signs may change any cycle
    always @(negedge clk_sys_i) begin
        {sign_a_o, sign_b_o, data_a_o, data_b_o} <= nxt_i;
    end
endmodule // emb_fabric_model

//--- testbench/emb_mult_tb_top.sv
// Self-checking bench of the embedded multiplier
module emb_mult_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, ce = 1'b1, sar = 1'b0, sbr = 1'b0, sa, sb, rs;
    logic [3:0] in_reg = 4'h0;
    logic [1:0] out_reg = 2'h0;
    logic [37:0] nxt = 38'h0;
    logic [17:0] da, db;
    logic [35:0] res;
    logic [7:0] cfgs [4] = '{8'h00, 8'h0c, 8'hf3, 8'hff};
    emb_pkg::emb_mode_t mode = emb_pkg::EMB_MODE_WIDE;
    int bad_count = 0, total_checks = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    emb_fabric_model u_fab (.clk_sys_i(clk_sys_i), .nxt_i(nxt), .data_a_o(da), .data_b_o(db), .sign_a_o(sa),
        .sign_b_o(sb));
    emb_mult u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .mode_i(mode), .data_a_i(da),
        .data_b_i(db), .sign_a_i(sa), .sign_b_i(sb), .in_reg_en_i(in_reg), .sign_a_reg_en_i(sar),
        .sign_b_reg_en_i(sbr), .out_reg_en_i(out_reg), .result_o(res), .result_signed_o(rs));
    // Expected product of the packed signs and operands
    function automatic logic [35:0] prod_of(logic m, logic [37:0] v);
        if (m == 1'b0) return 36'($signed({v[37] & v[35], v[35:18]}) * $signed({v[36] & v[17], v[17:0]}));
        return {18'($signed({v[37] & v[35], v[35:27]}) * $signed({v[36] & v[17], v[17:9]})),
            18'($signed({v[37] & v[26], v[26:18]}) * $signed({v[36] & v[8], v[8:0]}))};
    endfunction
    task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end
    initial begin
        logic [37:0] v;
        logic [8:0] r;
        void'($urandom(54095));
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i) sys_rst_i <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            v = 38'({$urandom, $urandom});
            r = 9'($urandom);
            if (i < 32) begin
                v = {i[1:0], 18'h20100, 18'h3ffff};
                r = {i[4], cfgs[i[3:2]]};
            end
            @(negedge clk_sys_i);
            nxt <= v;
            mode <= emb_pkg::emb_mode_t'(r[8]);
            {in_reg, out_reg, sar, sbr} <= r[7:0];
            repeat (3) @(negedge clk_sys_i);
            chk("result", prod_of(r[8], v), res);
            chk("signed", {35'h0, v[37] | v[36]}, {35'h0, rs});
        end
        @(negedge clk_sys_i);
        ce <= 1'b0;
        {in_reg, out_reg, sar, sbr} <= 8'hff;
        nxt <= ~v;
        repeat (3) @(negedge clk_sys_i);
        chk("frozen", prod_of(r[8], v), res);
        sys_rst_i <= 1'b1;
        #1;
        chk("cleared", 36'h0, res);
        @(negedge clk_sys_i) sys_rst_i <= 1'b0;
        wrap_up();
    end
endmodule // emb_mult_tb_top
